// file: afc_pkg.sv
// Package: register map, field layout, reset values and timing constants of the fan loop
package afc_pkg;

    // ==========================================================
    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_CFG1     = 8'h00;
    localparam logic [7:0] IDX_FANCHAR  = 8'h20;
    localparam logic [7:0] IDX_MINDUTY  = 8'h22;
    localparam logic [7:0] IDX_FILTER   = 8'h23;
    localparam logic [7:0] IDX_LOCTHR   = 8'h24;
    localparam logic [7:0] IDX_REMTHR   = 8'h25;
    localparam logic [7:0] IDX_LOCTEMP  = 8'h30;
    localparam logic [7:0] IDX_REMTEMP  = 8'h31;
    localparam logic [7:0] IDX_STATUS   = 8'h32;
    localparam int         ADDR_W       = 10;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CFG1     = 8'h80;
    localparam logic [7:0] RST_FANCHAR  = 8'h1D;
    localparam logic [7:0] RST_MINDUTY  = 8'h05;
    localparam logic [7:0] RST_FILTER   = 8'h10;
    localparam logic [7:0] RST_LOCTHR   = 8'h43;
    localparam logic [7:0] RST_REMTHR   = 8'h63;

    // ==========================================================
    // Field positions
    localparam int CFG_AUTO_BIT  = 7;
    localparam int CFG_SEL_LO    = 5;
    localparam int FCH_SPIN_LO   = 0;
    localparam int FCH_FREQ_LO   = 3;
    localparam int FCH_RANGE_LO  = 6;
    localparam int FLT_EN_BIT    = 0;
    localparam int FLT_RATE_LO   = 2;
    localparam int FLT_STEP_LO   = 5;
    localparam int FLT_SPIN_DIS  = 7;
    localparam int THR_SPAN_LO   = 0;
    localparam int THR_TMIN_LO   = 3;

    // ==========================================================
    // Loop constants
    localparam logic [7:0] SLOTS_PER_PERIOD = 8'hF0;   // 240 slots
    localparam logic [3:0] DUTY_FULL        = 4'hF;
    localparam logic [7:0] SLOTS_PER_CODE   = 8'h10;   // 240 / 15
    localparam logic [1:0] SEL_REMOTE       = 2'h0;
    localparam logic [1:0] SEL_MAXOF        = 2'h3;

    // Timing: clock and sample rates
    localparam int CLK_HZ       = 100_000_000;
    localparam int SPIN_UNIT_MS = 200;
    localparam int SPIN_UNIT_CYC = CLK_HZ / 1000 * SPIN_UNIT_MS;
    localparam int BASE_RATE_MHZ = 87500;              // 87.5 Hz in mHz
    localparam int UPD_PER_SMPL  = 1400;               // samples per update at 1.4 kHz = 1 Hz
    localparam int UPD_BASE_CYC  = 16 * CLK_HZ;        // 0.0625 updates/s at code 000

    // PWM frequencies in centihertz, codes 000..111
    localparam int PWM_CHZ [8] = '{1170, 1560, 2340, 3125, 3750, 4690, 6250, 9350};

    // Bundle of threshold settings for one channel
    typedef struct packed {
        logic [4:0] tmin;
        logic [2:0] span;
    } afc_thr_t;

endpackage : afc_pkg

// file: afc_chan.sv
// Per-channel duty calculator: temperature to duty in slots
module afc_chan (
    // Settings
    input  wire afc_pkg::afc_thr_t thr,
    input  wire logic [3:0]        min_code,
    // Temperature in whole degrees
    input  wire logic [7:0]        temp,
    // Duty in slots, 0..240
    output logic      [7:0]        duty_slots
);
    logic [7:0]  tmin_c;
    logic [7:0]  span_c;
    logic [15:0] excess;
    logic [15:0] codes;
    logic [15:0] code;

    // Fan-on temperature in 4 degree steps, span table in degrees
    always_comb begin
        tmin_c = {1'b0, thr.tmin, 2'b00};
        case (thr.span)
            3'h0: span_c = 8'h05;
            3'h1: span_c = 8'h0A;
            3'h2: span_c = 8'h14;
            3'h3: span_c = 8'h28;
            default: span_c = 8'h50;
        endcase
        excess = (temp >= tmin_c) ? {8'h00, temp - tmin_c} : 16'h0000;
        // One code per span/10 degrees above fan-on temperature
        codes = 16'((excess * 16'd10) / {8'h00, span_c});
        code  = codes + {12'h000, min_code};
        if (temp < tmin_c) begin
            duty_slots = 8'h00;
        end else if (code >= {12'h000, afc_pkg::DUTY_FULL}) begin
            duty_slots = afc_pkg::SLOTS_PER_PERIOD;
        end else begin
            duty_slots = 8'(code[3:0] * afc_pkg::SLOTS_PER_CODE);
        end
    end
endmodule : afc_chan

// file: afc_fan_loop.sv
// Temperature-driven fan PWM loop with AXI4-Lite register slave
module afc_fan_loop #(
    parameter int CLK_HZ = afc_pkg::CLK_HZ,
    parameter int UPD_BASE_CYC = afc_pkg::UPD_BASE_CYC,
    parameter int SPIN_UNIT_CYC = afc_pkg::SPIN_UNIT_CYC
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // AXI4-Lite write address and data
    input  wire logic [afc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // AXI4-Lite read
    input  wire logic [afc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Temperatures from the measurement block, whole degrees
    input  wire logic [7:0]                local_temp,
    input  wire logic [7:0]                remote_temp,
    // Fan drive and tach range for the tach counter
    output logic                           pwm_out,
    output logic [3:0]                     tach_divisor
);
    // ==========================================================
    // Registers
    logic [7:0] cfg1_ff, fanchar_ff, minduty_ff, filter_ff, locthr_ff, remthr_ff;
    logic [7:0] duty_ff, nxt_duty;
    logic [7:0] slot_ff;
    logic [31:0] presc_ff;
    logic [31:0] upd_cnt_ff;
    logic [31:0] spin_cnt_ff;
    logic        spin_ff;
    logic        auto_q_ff;
    logic        aw_ff, w_ff;
    logic [afc_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;

    // ==========================================================
    // Write channel: latch address and data in either order
    // Both halves stay latched until the write and its response issue together
    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_ff && !s_axi_bvalid;
    assign s_axi_bresp   = 2'b00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (aw_ff && w_ff) begin
                aw_ff <= 1'b0;
                w_ff  <= 1'b0;
            end
        end
    end

    // Response follows once both halves are in
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
        end else if (aw_ff && w_ff) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic       wr_go;
    logic [7:0] wr_idx;
    assign wr_go  = aw_ff && w_ff && wstrb_ff[0];
    assign wr_idx = awaddr_ff[afc_pkg::ADDR_W-1:2];

    // Register file writes; unmapped offsets are ignored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg1_ff    <= afc_pkg::RST_CFG1;
            fanchar_ff <= afc_pkg::RST_FANCHAR;
            minduty_ff <= afc_pkg::RST_MINDUTY;
            filter_ff  <= afc_pkg::RST_FILTER;
            locthr_ff  <= afc_pkg::RST_LOCTHR;
            remthr_ff  <= afc_pkg::RST_REMTHR;
        end else if (wr_go) begin
            case (wr_idx)
                afc_pkg::IDX_CFG1:    cfg1_ff    <= wdata_ff[7:0];
                afc_pkg::IDX_FANCHAR: fanchar_ff <= wdata_ff[7:0];
                afc_pkg::IDX_MINDUTY: minduty_ff <= {4'h0, wdata_ff[3:0]};
                afc_pkg::IDX_FILTER:  filter_ff  <= {wdata_ff[7:2], 1'b0, wdata_ff[0]};
                afc_pkg::IDX_LOCTHR:  locthr_ff  <= wdata_ff[7:0];
                afc_pkg::IDX_REMTHR:  remthr_ff  <= wdata_ff[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Read channel: one-cycle answer, unmapped reads give zero
    // Read data is registered at the address edge, so a later change is not torn
    logic [7:0] rd_val;
    logic [7:0] rd_idx;
    assign rd_idx        = s_axi_araddr[afc_pkg::ADDR_W-1:2];
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = 2'b00;

    always_comb begin
        case (rd_idx)
            afc_pkg::IDX_CFG1:    rd_val = cfg1_ff;
            afc_pkg::IDX_FANCHAR: rd_val = fanchar_ff;
            afc_pkg::IDX_MINDUTY: rd_val = minduty_ff;
            afc_pkg::IDX_FILTER:  rd_val = filter_ff;
            afc_pkg::IDX_LOCTHR:  rd_val = locthr_ff;
            afc_pkg::IDX_REMTHR:  rd_val = remthr_ff;
            afc_pkg::IDX_LOCTEMP: rd_val = local_temp;
            afc_pkg::IDX_REMTEMP: rd_val = remote_temp;
            afc_pkg::IDX_STATUS:  rd_val = duty_ff;
            default:              rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_val};
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Register fields by name; positions come from the package
    logic       auto_mode;
    logic [1:0] src_sel;
    logic       filt_en;
    logic [1:0] step_code;
    logic       spin_off;
    logic [2:0] spin_code;
    logic [2:0] freq_code;
    logic [1:0] range_code;
    assign auto_mode  = cfg1_ff[afc_pkg::CFG_AUTO_BIT];
    assign src_sel    = cfg1_ff[afc_pkg::CFG_SEL_LO +: 2];
    assign filt_en    = filter_ff[afc_pkg::FLT_EN_BIT];
    assign step_code  = filter_ff[afc_pkg::FLT_STEP_LO +: 2];
    assign spin_off   = filter_ff[afc_pkg::FLT_SPIN_DIS];
    assign spin_code  = fanchar_ff[afc_pkg::FCH_SPIN_LO +: 3];
    assign freq_code  = fanchar_ff[afc_pkg::FCH_FREQ_LO +: 3];
    assign range_code = fanchar_ff[afc_pkg::FCH_RANGE_LO +: 2];

    // ==========================================================
    // Channel calculators and source selection
    logic [7:0] loc_slots, rem_slots, target;

    afc_chan u_loc (
        .thr        (afc_pkg::afc_thr_t'(locthr_ff)),
        .min_code   (minduty_ff[3:0]),
        .temp       (local_temp),
        .duty_slots (loc_slots)
    );

    afc_chan u_rem (
        .thr        (afc_pkg::afc_thr_t'(remthr_ff)),
        .min_code   (minduty_ff[3:0]),
        .temp       (remote_temp),
        .duty_slots (rem_slots)
    );

    // Pick the controlling loop; software mode uses the min duty nibble directly
    always_comb begin
        if (!auto_mode) begin
            target = 8'(minduty_ff[3:0] * afc_pkg::SLOTS_PER_CODE);
        end else if (src_sel == afc_pkg::SEL_MAXOF) begin
            target = (loc_slots > rem_slots) ? loc_slots : rem_slots;
        end else begin
            target = rem_slots;
        end
    end

    // ==========================================================
    // Update tick: period from sample rate code, halving per code
    // A new rate code takes effect at the next reload, not in mid-count
    logic       upd_tick;
    logic [2:0] rate_code;
    assign rate_code = filter_ff[afc_pkg::FLT_RATE_LO +: 3];
    assign upd_tick  = (upd_cnt_ff == 32'h0000_0000);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            upd_cnt_ff <= 32'h0000_0000;
        end else if (upd_tick) begin
            upd_cnt_ff <= 32'(UPD_BASE_CYC >> rate_code) - 32'h0000_0001;
        end else begin
            upd_cnt_ff <= upd_cnt_ff - 32'h0000_0001;
        end
    end

    // Ramp step in slots from the step field
    logic [7:0] step;
    assign step = 8'h01 << step_code;

    // Duty update: direct, or ramped one step per update
    // A step larger than the gap lands on the target, so the ramp never hunts
    always_comb begin
        nxt_duty = duty_ff;
        if (!filt_en || !auto_mode) begin
            nxt_duty = target;
        end else if (upd_tick) begin
            if (target > duty_ff) begin
                nxt_duty = (target - duty_ff > step) ? duty_ff + step : target;
            end else if (target < duty_ff) begin
                nxt_duty = (duty_ff - target > step) ? duty_ff - step : target;
            end
        end
    end

    // Stored duty drives the output and is the previous value for the ramp
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            duty_ff <= 8'h00;
        end else begin
            duty_ff <= nxt_duty;
        end
    end

    // ==========================================================
    // Spin-up: full drive for the set time when the fan starts from zero
    logic [31:0] spin_len;
    always_comb begin
        case (spin_code)
            3'h0:    spin_len = 32'(SPIN_UNIT_CYC);
            3'h1:    spin_len = 32'(SPIN_UNIT_CYC * 2);
            3'h2:    spin_len = 32'(SPIN_UNIT_CYC * 3);
            3'h3:    spin_len = 32'(SPIN_UNIT_CYC * 4);
            3'h4:    spin_len = 32'(SPIN_UNIT_CYC * 5);
            3'h5:    spin_len = 32'(SPIN_UNIT_CYC * 10);
            3'h6:    spin_len = 32'(SPIN_UNIT_CYC * 20);
            default: spin_len = 32'(SPIN_UNIT_CYC * 40);
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            spin_ff     <= 1'b0;
            spin_cnt_ff <= 32'h0000_0000;
            auto_q_ff   <= 1'b0;
        end else begin
            // Edge detector resets to zero like the duty, so reset cannot fake a start
            auto_q_ff <= (duty_ff != 8'h00);
            if (!auto_q_ff && duty_ff != 8'h00 && !spin_off) begin
                spin_ff     <= 1'b1;
                spin_cnt_ff <= spin_len;
            end else if (spin_ff) begin
                if (spin_cnt_ff <= 32'h0000_0001) begin
                    spin_ff <= 1'b0;
                end
                spin_cnt_ff <= spin_cnt_ff - 32'h0000_0001;
            end
        end
    end

    // ==========================================================
    // PWM: 240 slots per period, slot length from frequency code
    localparam int SLOTS  = int'(afc_pkg::SLOTS_PER_PERIOD);
    localparam int CHZ_HZ = 100;                                    // Table is in centihertz
    logic [31:0] slot_len;
    assign slot_len = 32'((CLK_HZ / SLOTS) * CHZ_HZ / afc_pkg::PWM_CHZ[freq_code]);

    // Wrap on >= so a shorter slot after a frequency change cannot run away

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            presc_ff <= 32'h0000_0000;
            slot_ff  <= 8'h00;
        end else if (presc_ff + 32'h0000_0001 >= slot_len) begin
            presc_ff <= 32'h0000_0000;
            slot_ff  <= (slot_ff == afc_pkg::SLOTS_PER_PERIOD - 8'h01) ? 8'h00 : slot_ff + 8'h01;
        end else begin
            presc_ff <= presc_ff + 32'h0000_0001;
        end
    end

    // High for duty slots out of 240: 80 slots gives 33%
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= spin_ff || (slot_ff < duty_ff);
        end
    end

    // Tach divisor 1, 2, 4, 8 for the tach counter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tach_divisor <= 4'h1;
        end else begin
            tach_divisor <= 4'h1 << range_code;
        end
    end

endmodule : afc_fan_loop

// file: afc_fan_model.sv
// Fan model: measures period and high time of the drive signal
module afc_fan_model (
    // Clock and fan drive
    input  wire logic clock,
    input  wire logic pwm_in,
    // Last measured high time and period in cycles
    output int        high_cyc,
    output int        period_cyc
);
    timeunit 1ns;
    timeprecision 1ps;
    int   hc_ff   = 0;
    int   pc_ff   = 0;
    logic prev_ff = 1'b0;
    // A rising edge closes one period and starts the next
    always @(posedge clock) begin
        prev_ff <= pwm_in;
        if (pwm_in && !prev_ff) begin
            high_cyc   <= hc_ff;
            period_cyc <= pc_ff;
            hc_ff      <= 1;
            pc_ff      <= 1;
        end else begin
            hc_ff <= hc_ff + (pwm_in ? 1 : 0);
            pc_ff <= pc_ff + 1;
        end
    end
endmodule : afc_fan_model

// file: afc_fan_loop_properties.sv
// Checker of the fan loop register bus and tach range output
module afc_fan_loop_properties (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Tach range
    input wire logic [3:0]  tach_divisor
);
    // ==========================================================
    // Handshake and range properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("write response timing");
    read_okay_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0)
        else $error("read response or upper bits wrong");
    write_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    tach_range_a: assert property (tach_divisor inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("tach divisor out of range");
endmodule : afc_fan_loop_properties

bind afc_fan_loop afc_fan_loop_properties u_props (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tach_divisor);

// file: afc_fan_loop_tb.sv
// Testbench of the fan loop: registers, software duty, automatic and filtered loop
module afc_fan_loop_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UPD = 800;  // Update period at rate code 000
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, pwm_out;
    logic [1:0]  bresp, rresp;
    logic [3:0]  tach_divisor;
    logic [7:0]  ltemp = 8'h00, rtemp = 8'h00, d0, d1;
    int          high_cyc, period_cyc, num_errors = 0, tests_run = 0, cycles = 0;
    logic [7:0]  cs [6][4] = '{'{8'hE0, 8'h14, 8'h2C, 8'hA0}, '{8'hE0, 8'h3C, 8'h2C, 8'hF0},
        '{8'hE0, 8'h0A, 8'h00, 8'h00}, '{8'h80, 8'h3C, 8'h2C, 8'hA0},
        '{8'h80, 8'hC8, 8'hC8, 8'hF0}, '{8'h80, 8'h3C, 8'h00, 8'h00}};
    afc_fan_loop #(.CLK_HZ(224400), .UPD_BASE_CYC(UPD), .SPIN_UNIT_CYC(50)) uut (.clock(clock),
        .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .local_temp(ltemp), .remote_temp(rtemp), .pwm_out(pwm_out), .tach_divisor(tach_divisor));
    afc_fan_model fan (.clock(clock), .pwm_in(pwm_out), .high_cyc(high_cyc),
        .period_cyc(period_cyc));
    // ==========================================================
    // Clock, watchdog and bus tasks
    initial begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            num_errors++;
            $display("mismatch at %0t: run too long", $time);
            report_and_stop();
        end
    end
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge clock);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awvalid && awready) aw_done = 1;
            if (wvalid && wready) w_done = 1;
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end while (!(aw_done && w_done));
        do @(posedge clock); while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val);
        @(posedge clock);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        val = rdata[7:0];
        rready <= 1'b0;
    endtask : rd_reg
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd_reg(idx, v);
        chk(v, exp, what);
    endtask : rc
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rc(8'h00, 8'h80, "cfg reset");
        rc(8'h20, 8'h1D, "fan char reset");
        rc(8'h22, 8'h05, "min duty reset");
        rc(8'h23, 8'h10, "filter reset");
        rc(8'h24, 8'h43, "local thr reset");
        rc(8'h25, 8'h63, "remote thr reset");
        chk(tach_divisor, 16'h1, "tach reset");
        for (int i = 3; i >= 0; i--) begin
            wr(8'h20, {i[1:0], 6'h38});
            rc(8'h20, {i[1:0], 6'h38}, "fan char");
            chk(tach_divisor, 16'(1 << i), "tach");
        end
        wr(8'h3F, 8'hFF);
        rc(8'h3F, 8'h00, "unmapped");
        $display("test registers done");
        // Software duty at 93.5 Hz: 10 cycles a slot
        wr(8'h23, 8'h80);
        wr(8'h00, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(8'h22, i ? 8'h0A : 8'h05);
            repeat (7200) @(posedge clock);
            chk(16'(period_cyc), 16'd2400, "period");
            chk(16'(high_cyc), i ? 16'd1600 : 16'd800, "high time");
            rc(8'h32, i ? 8'hA0 : 8'h50, "soft duty");
        end
        // Spin-up from zero duty: full drive for 40 units of 50 cycles
        wr(8'h22, 8'h00);
        wr(8'h20, 8'h3F);
        wr(8'h23, 8'h00);
        wr(8'h22, 8'h01);
        repeat (3) @(posedge clock);
        d0 = 8'h00;
        repeat (1900) begin
            @(posedge clock);
            if (pwm_out !== 1'b1) d0 = 8'h01;
        end
        chk(d0, 8'h00, "spin held");
        repeat (7200) @(posedge clock);
        chk(16'(high_cyc), 16'd160, "after spin");
        $display("test software duty done");
        // Automatic loop, unfiltered
        wr(8'h22, 8'h05);
        wr(8'h24, 8'h2B);
        wr(8'h25, 8'h0C);
        for (int i = 0; i < 6; i++) begin
            wr(8'h00, cs[i][0]);
            ltemp <= cs[i][1];
            rtemp <= cs[i][2];
            repeat (4) @(posedge clock);
            rc(8'h32, cs[i][3], "auto duty");
        end
        $display("test automatic loop done");
        // Filtered loop: set up before entering automatic mode
        wr(8'h00, 8'h00);
        wr(8'h23, 8'h81);
        ltemp <= 8'h3C;
        wr(8'h00, 8'hE0);
        for (int i = 0; i < 5; i++) begin
            wr(8'h23, 8'h81 | (i < 4 ? 8'(i << 5) : 8'h60));
            if (i == 4) ltemp <= 8'h0A;
            rd_reg(8'h32, d0);
            repeat (UPD - 3) @(posedge clock);
            rd_reg(8'h32, d1);
            chk(i < 4 ? d1 - d0 : d0 - d1, i < 4 ? 16'(1 << i) : 16'h8, "ramp");
        end
        ltemp <= 8'h28;
        for (int k = 0; k < 40 && d1 !== 8'hA0; k++) begin
            repeat (UPD) @(posedge clock);
            rd_reg(8'h32, d1);
        end
        repeat (UPD) @(posedge clock);
        rc(8'h32, 8'hA0, "ramp landing");
        wr(8'h23, 8'h80);
        ltemp <= 8'h3C;
        repeat (4) @(posedge clock);
        rc(8'h32, 8'hF0, "filter off");
        $display("test filtered loop done");
        report_and_stop();
    end
endmodule : afc_fan_loop_tb
